//--- supply_pkg.sv
/*
  Constants and types shared by the supply supervisor and regulator control.
  Assumes a single 20 MHz clock domain and digital comparator levels.
*/
package supply_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int OPT_LOAD_NS = 1000;
  localparam int OPT_LOAD_CYCLES = (OPT_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  // ------------------------------------------------------------
  // Threshold selections
  // ------------------------------------------------------------
  localparam int BROWNOUT_LEVELS = 5;
  localparam int MONITOR_LEVELS = 7;
  localparam logic [2:0] BROWNOUT_SEL_RESET = 3'h0;
  localparam logic [2:0] BROWNOUT_SEL_MAX = 3'h4;
  localparam logic [2:0] MONITOR_SEL_MAX = 3'h6;
  localparam logic [2:0] MONITOR_SEL_RESET = 3'h0;

  // ------------------------------------------------------------
  // Interrupt edge selection field positions
  // ------------------------------------------------------------
  localparam int EDGE_FALL_BIT = 0;
  localparam int EDGE_RISE_BIT = 1;

  // ------------------------------------------------------------
  // Modes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_RUN,
    PWR_SLEEP,
    PWR_LP_RUN,
    PWR_LP_SLEEP,
    PWR_STOP,
    PWR_STANDBY
  } power_mode_t;

  typedef enum logic [1:0] {
    REG_MAIN,
    REG_LOW_POWER,
    REG_POWER_DOWN
  } regulator_mode_t;

endpackage : supply_pkg

//--- comparator_if.sv
/*
  Carrier for synchronised comparator levels between design modules.
  Assumes producer and consumer share ref_clk.
*/
`timescale 1ns/1ps
interface comparator_if;
  logic supply_ok;
  logic brownout_ok;
  logic monitor_above;

  modport producer (output supply_ok, output brownout_ok, output monitor_above);
  modport consumer (input supply_ok, input brownout_ok, input monitor_above);
endinterface : comparator_if

//--- level_sync.sv
/*
  Two-flop synchroniser for one asynchronous level.
  Assumes a synchronous active-high reset on the same clock.
*/
`timescale 1ns/1ps
module level_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Level in and out
  input wire logic async_in,
  output logic sync_out
);

  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  // Next values of both stages
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // Register stages
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule : level_sync

//--- supply_supervisor_regulator_ctrl.sv
/*
  Supply supervision and regulator mode control.
  Assumes comparator levels from analog blocks are asynchronous, option
  byte values are held stable by the loader while it reports done, and
  power mode requests come from the power-mode controller on ref_clk.
*/
`timescale 1ns/1ps

module supply_supervisor_regulator_ctrl #(
  parameter int OPT_LOAD_CYCLES_P = supply_pkg::OPT_LOAD_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Analog comparator levels (asynchronous)
  input wire logic power_on_down_reset_ok,
  input wire logic brownout_detector_ok,
  input wire logic supply_level_monitor_above,
  // Option byte loader
  input wire logic opt_load_done,
  input wire logic opt_brownout_enable,
  input wire logic [2:0] opt_brownout_sel,
  output logic opt_load_start,
  // Software configuration
  input wire logic monitor_enable,
  input wire logic [2:0] monitor_level_sel,
  input wire logic [1:0] monitor_edge_sel,
  input wire logic monitor_irq_clear,
  input wire logic vref_off_in_stop,
  // Device power mode
  input wire supply_pkg::power_mode_t power_mode,
  // Outputs to analog and system
  output logic internal_reset,
  output logic brownout_active,
  output logic [2:0] brownout_threshold_sel,
  output logic monitor_active,
  output logic [2:0] monitor_threshold_sel,
  output logic monitor_irq,
  output logic monitor_above,
  output logic internal_voltage_reference_on,
  output supply_pkg::regulator_mode_t regulator_mode,
  output logic kernel_power_on,
  output logic kernel_state_lost
);
  import supply_pkg::*;

  // ------------------------------------------------------------
  // Comparator synchronisation
  // ------------------------------------------------------------
  comparator_if cmp ();

  level_sync #(.RESET_VALUE(1'b0)) sync_supply (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(power_on_down_reset_ok),
    .sync_out(cmp.supply_ok)
  );
  level_sync #(.RESET_VALUE(1'b0)) sync_brownout (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(brownout_detector_ok),
    .sync_out(cmp.brownout_ok)
  );
  level_sync #(.RESET_VALUE(1'b0)) sync_mon (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(supply_level_monitor_above),
    .sync_out(cmp.monitor_above)
  );

  // ------------------------------------------------------------
  // Start-up sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_WAIT_SUPPLY,
    SEQ_LOAD,
    SEQ_READY
  } seq_state_t;

  seq_state_t seq_reg;
  seq_state_t seq_next;
  logic [15:0] load_cnt_reg;
  logic [15:0] load_cnt_next;
  logic brownout_en_reg;
  logic brownout_en_next;
  logic [2:0] brownout_sel_reg;
  logic [2:0] brownout_sel_next;
  logic supply_low;

  // reset while low; brownout counts only while enabled
  always_comb begin
    supply_low = !cmp.supply_ok || (brownout_en_reg && !cmp.brownout_ok);
  end

  // Sequencer next state and option capture
  always_comb begin
    seq_next = seq_reg;
    load_cnt_next = load_cnt_reg;
    brownout_en_next = brownout_en_reg;
    brownout_sel_next = brownout_sel_reg;
    case (seq_reg)
      SEQ_WAIT_SUPPLY: begin
        // Load time restarts after every supply dip
        load_cnt_next = 16'h0000;
        if (!supply_low) begin
          seq_next = SEQ_LOAD;
        end
      end
      SEQ_LOAD: begin
        if (supply_low) begin
          // Supply lost mid-load, start over
          seq_next = SEQ_WAIT_SUPPLY;
        end else if (opt_load_done && (32'(load_cnt_reg) + 1 >= OPT_LOAD_CYCLES_P)) begin
          // options confirm, change or disable brownout
          brownout_en_next = opt_brownout_enable;
          if (opt_brownout_sel > BROWNOUT_SEL_MAX) begin
            brownout_sel_next = BROWNOUT_SEL_MAX;
          end else begin
            brownout_sel_next = opt_brownout_sel;
          end
          seq_next = SEQ_READY;
        end else if (32'(load_cnt_reg) + 1 < OPT_LOAD_CYCLES_P) begin
          // Minimum load time, done ignored until it elapses
          load_cnt_next = load_cnt_reg + 16'h0001;
        end
      end
      SEQ_READY: begin
        if (supply_low) begin
          seq_next = SEQ_WAIT_SUPPLY;
        end
      end
      default: begin
        seq_next = SEQ_WAIT_SUPPLY;
      end
    endcase
  end

  // Sequencer registers; brownout active from power-on by default
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seq_reg <= SEQ_WAIT_SUPPLY;
      load_cnt_reg <= 16'h0000;
      brownout_en_reg <= 1'b1;
      brownout_sel_reg <= BROWNOUT_SEL_RESET;
    end else begin
      seq_reg <= seq_next;
      load_cnt_reg <= load_cnt_next;
      brownout_en_reg <= brownout_en_next;
      brownout_sel_reg <= brownout_sel_next;
    end
  end

  // ------------------------------------------------------------
  // Supply level monitor
  // ------------------------------------------------------------
  logic mon_prev_reg;
  logic mon_prev_next;
  logic mon_irq_reg;
  logic mon_irq_next;
  logic [2:0] mon_sel_reg;
  logic [2:0] mon_sel_next;
  logic mon_fall;
  logic mon_rise;
  logic mon_on;

  always_comb begin
    mon_on = monitor_enable && (seq_reg == SEQ_READY);
    if (monitor_level_sel > MONITOR_SEL_MAX) begin
      mon_sel_next = MONITOR_SEL_MAX;
    end else begin
      mon_sel_next = monitor_level_sel;
    end
    // Level follows the comparator only while active
    mon_prev_next = mon_prev_reg;
    if (mon_on) begin
      mon_prev_next = cmp.monitor_above;
    end
    // Edges against the last sampled level
    mon_fall = mon_on && mon_prev_reg && !cmp.monitor_above;
    mon_rise = mon_on && !mon_prev_reg && cmp.monitor_above;
    mon_irq_next = mon_irq_reg;
    if (monitor_irq_clear) begin
      mon_irq_next = 1'b0;
    end
    if ((mon_fall && monitor_edge_sel[EDGE_FALL_BIT]) ||
        (mon_rise && monitor_edge_sel[EDGE_RISE_BIT])) begin
      mon_irq_next = 1'b1;
    end
  end

  // Monitor registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mon_prev_reg <= 1'b0;
      mon_irq_reg <= 1'b0;
      mon_sel_reg <= MONITOR_SEL_RESET;
    end else begin
      mon_prev_reg <= mon_prev_next;
      mon_irq_reg <= mon_irq_next;
      mon_sel_reg <= mon_sel_next;
    end
  end

  // ------------------------------------------------------------
  // Regulator and reference control
  // ------------------------------------------------------------
  regulator_mode_t reg_mode_reg;
  regulator_mode_t reg_mode_next;
  logic vref_on_reg;
  logic vref_on_next;
  logic lost_reg;
  logic lost_next;

  // Mode decode from device power mode
  always_comb begin
    case (power_mode)
      PWR_RUN, PWR_SLEEP: begin
        reg_mode_next = REG_MAIN;
      end
      PWR_LP_RUN, PWR_LP_SLEEP, PWR_STOP: begin
        reg_mode_next = REG_LOW_POWER;
      end
      PWR_STANDBY: begin
        reg_mode_next = REG_POWER_DOWN;
      end
      default: begin
        reg_mode_next = REG_MAIN;
      end
    endcase
    vref_on_next = 1'b1;
    if ((power_mode == PWR_STOP) && vref_off_in_stop) begin
      vref_on_next = 1'b0;
    end
    // Reference always off in Standby
    if (power_mode == PWR_STANDBY) begin
      vref_on_next = 1'b0;
    end
    lost_next = lost_reg;
    if (power_mode == PWR_STANDBY) begin
      lost_next = 1'b1;
    end else if (power_mode == PWR_RUN) begin
      lost_next = 1'b0;
    end
  end

  // Regulator registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_mode_reg <= REG_MAIN;
      vref_on_reg <= 1'b1;
      lost_reg <= 1'b0;
    end else begin
      reg_mode_reg <= reg_mode_next;
      vref_on_reg <= vref_on_next;
      lost_reg <= lost_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // internal reset held until ready
  assign internal_reset = (seq_reg != SEQ_READY);
  assign opt_load_start = (seq_reg == SEQ_LOAD);

  assign brownout_active = brownout_en_reg;
  assign brownout_threshold_sel = brownout_sel_reg;

  assign monitor_active = mon_on;
  assign monitor_threshold_sel = mon_sel_reg;
  assign monitor_irq = mon_irq_reg;
  assign monitor_above = mon_prev_reg;

  assign internal_voltage_reference_on = vref_on_reg;
  assign regulator_mode = reg_mode_reg;
  assign kernel_power_on = (reg_mode_reg != REG_POWER_DOWN);
  assign kernel_state_lost = lost_reg;

endmodule : supply_supervisor_regulator_ctrl

//--- supply_checker_assertions.sv
/* Port checker for the supply supervisor.
   Assumes it is bound onto the top module. */
`timescale 1ns/1ps
module supply_checker
  import supply_pkg::*;
(
  // Clock, reset and inputs
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic power_on_down_reset_ok,
  input wire logic opt_brownout_enable,
  input wire logic monitor_enable,
  input wire logic [1:0] monitor_edge_sel,
  input wire logic vref_off_in_stop,
  input wire supply_pkg::power_mode_t power_mode,
  // Outputs watched
  input wire logic internal_reset,
  input wire logic brownout_active,
  input wire logic monitor_active,
  input wire logic monitor_irq,
  input wire logic internal_voltage_reference_on,
  input wire supply_pkg::regulator_mode_t regulator_mode,
  input wire logic kernel_power_on,
  input wire logic kernel_state_lost
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_reset_low_supply: assert property (!power_on_down_reset_ok [*4] |-> internal_reset)
    else $error("reset not held");
  chk_brownout_load: assert property (
    $fell(internal_reset) |-> brownout_active == $past(opt_brownout_enable))
    else $error("brownout option lost");
  chk_main_in_run: assert property (
    power_mode == PWR_RUN |=> regulator_mode == REG_MAIN) else $error("run not main");
  chk_low_power_modes: assert property (
    power_mode inside {PWR_LP_RUN, PWR_LP_SLEEP, PWR_STOP} |=> regulator_mode == REG_LOW_POWER)
    else $error("low power mode wrong");
  chk_standby_down: assert property (power_mode == PWR_STANDBY |=>
    regulator_mode == REG_POWER_DOWN && !kernel_power_on && kernel_state_lost)
    else $error("standby wrong");
  chk_vref_in_stop: assert property (power_mode == PWR_STOP |=>
    internal_voltage_reference_on == !$past(vref_off_in_stop)) else $error("vref wrong");
  chk_monitor_enable: assert property (!monitor_enable |-> !monitor_active)
    else $error("monitor active");
  chk_irq_cause: assert property ($rose(monitor_irq) |->
    $past(monitor_active) && $past(monitor_edge_sel) != 2'h0) else $error("irq no cause");
  // Main scenarios reached
  cover property ($rose(monitor_irq));
  cover property ($fell(internal_reset));
  cover property (regulator_mode == REG_POWER_DOWN);
endmodule : supply_checker

bind supply_supervisor_regulator_ctrl supply_checker i_chk (.*);

//--- supply_env_model.sv
/* Far side: comparators, option loader, power-mode controller.
   Assumes bench requests on ref_clk. */
`timescale 1ns/1ps
module supply_env_model
  import supply_pkg::*;
#(
  parameter int LOAD_DLY = 3
) (
  // Requests from the bench
  input wire logic ref_clk,
  input wire logic [2:0] lvl_req,
  input wire supply_pkg::power_mode_t mode_req,
  input wire logic opt_load_start,
  // Far-side outputs
  output logic power_on_down_reset_ok,
  output logic brownout_detector_ok,
  output logic supply_level_monitor_above,
  output logic opt_load_done,
  output supply_pkg::power_mode_t power_mode
);
  int cnt = 0;
  assign #13 {power_on_down_reset_ok, brownout_detector_ok, supply_level_monitor_above} = lvl_req;
  // Loader answers late, drops done with start
  always @(posedge ref_clk) begin
    cnt <= opt_load_start ? cnt + 1 : 0;
    opt_load_done <= opt_load_start && cnt >= LOAD_DLY;
    power_mode <= mode_req;
  end
endmodule : supply_env_model

//--- supply_supervisor_regulator_ctrl_test.sv
/* Self-checking bench for the supply supervisor.
   Assumes the package, the checker and the far-side model. */
`timescale 1ns/1ps
module supply_supervisor_regulator_ctrl_test;
  import supply_pkg::*;
  typedef struct {int due; logic [7:0] exp; int kind;} note_t;
  logic ref_clk = 1'h0, rst = 1'h1, opt_brownout_enable = 1'h1, monitor_enable = 1'h0;
  logic monitor_irq_clear = 1'h0, vref_off_in_stop = 1'h0, opt_load_start, opt_load_done;
  logic power_on_down_reset_ok, brownout_detector_ok, supply_level_monitor_above, monitor_irq;
  logic internal_reset, brownout_active, monitor_active, monitor_above, kernel_power_on;
  logic internal_voltage_reference_on, kernel_state_lost, lost;
  logic [2:0] lvl_req = 3'h0, opt_brownout_sel = 3'h0, monitor_level_sel = 3'h0, msel;
  logic [2:0] brownout_threshold_sel, monitor_threshold_sel;
  logic [1:0] monitor_edge_sel = 2'h0;
  logic [31:0] seed = 32'h6D6F;
  power_mode_t mode_req = PWR_RUN, power_mode;
  regulator_mode_t regulator_mode;
  int mismatches = 0, n_tests = 0, cyc = 0, m;
  note_t q[$];

  supply_supervisor_regulator_ctrl #(.OPT_LOAD_CYCLES_P(2)) i_dut (.*);
  supply_env_model i_env (.*);

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] view(input int k);
    case (k)
      0: return {3'h0, regulator_mode, internal_voltage_reference_on, kernel_power_on, kernel_state_lost};
      1: return {3'h0, internal_reset, brownout_active, brownout_threshold_sel};
      2: return {2'h0, monitor_above, monitor_active, monitor_irq, monitor_threshold_sel};
      default: return {6'h0, opt_load_start, internal_reset};
    endcase
  endfunction : view
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : step
  task automatic note(input int k, input int d, input logic [7:0] e);
    q.push_back('{cyc + d, e, k});
  endtask : note
  task automatic compare(input logic [7:0] e, input logic [7:0] a);
    n_tests++;
    if (a !== e) begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask : compare
  task automatic compare_mode(input logic [7:0] e);
    compare(e, view(0));
  endtask : compare_mode
  task automatic compare_startup(input logic [7:0] e);
    compare(e, view(1));
  endtask : compare_startup
  task automatic compare_monitor(input logic [7:0] e);
    compare(e, view(2));
  endtask : compare_monitor
  task automatic compare_reset(input logic [7:0] e);
    compare(e, view(3));
  endtask : compare_reset
  task automatic complete_run;
    // Notes never checked count as one miss
    if (q.size() > 0) mismatches++;
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic wait_ready;
    int i;
    for (i = 0; i < 60 && internal_reset !== 1'h0; i++) step(1);
    if (i == 60) begin
      mismatches++;
      complete_run();
    end
  endtask : wait_ready

  // Oldest note compared once due
  always @(negedge ref_clk) begin
    if (q.size() > 0 && q[0].due <= cyc) begin
      case (q[0].kind)
        0: compare_mode(q[0].exp);
        1: compare_startup(q[0].exp);
        2: compare_monitor(q[0].exp);
        default: compare_reset(q[0].exp);
      endcase
      void'(q.pop_front());
    end
  end

  // Main sequence
  initial begin
    step(3);
    rst = 1'h0;
    seed = lfsr(seed);
    {opt_brownout_enable, opt_brownout_sel} = seed[3:0];
    step(5);
    note(1, 0, 8'h18);
    lvl_req = 3'h6;
    wait_ready();
    note(1, 0, {4'h0, opt_brownout_enable, opt_brownout_sel > 3'h4 ? 3'h4 : opt_brownout_sel});
    $display("power-up test done");
    lost = 1'h0;
    for (int k = 0; k < 12; k++) begin
      m = k < 6 ? k : 11 - k;
      seed = lfsr(seed);
      vref_off_in_stop = seed[0];
      mode_req = power_mode_t'(m);
      lost = m == 5 ? 1'h1 : (m == 0 ? 1'h0 : lost);
      note(0, 3, {3'h0, m == 5 ? REG_POWER_DOWN : (m > 1 ? REG_LOW_POWER : REG_MAIN),
        !(m == 5 || (m == 4 && vref_off_in_stop)), m != 5, lost});
      step(4);
    end
    mode_req = PWR_RUN;
    $display("mode test done");
    seed = lfsr(seed);
    monitor_level_sel = seed[2:0];
    msel = monitor_level_sel > 3'h6 ? 3'h6 : monitor_level_sel;
    monitor_edge_sel = 2'h1;
    lvl_req = 3'h7;
    note(2, 4, {4'h0, 1'h0, msel});
    step(6);
    monitor_enable = 1'h1;
    note(2, 5, {2'h0, 1'h1, 1'h1, 1'h0, msel});
    step(6);
    for (int e = 0; e < 6; e++) begin
      monitor_edge_sel = 2'(e % 3 + 1);
      monitor_irq_clear = 1'h1;
      step(1);
      monitor_irq_clear = 1'h0;
      lvl_req[0] = ~lvl_req[0];
      note(2, 6, {2'h0, lvl_req[0], 1'h1, lvl_req[0] ? monitor_edge_sel[1] : monitor_edge_sel[0],
        msel});
      step(8);
    end
    $display("monitor test done");
    lvl_req = 3'h0;
    note(3, 5, 8'h01);
    step(7);
    lvl_req = 3'h7;
    note(3, 4, 8'h03);
    wait_ready();
    note(3, 0, 8'h00);
    step(4);
    $display("supply drop test done");
    complete_run();
  end
endmodule : supply_supervisor_regulator_ctrl_test
